// *** design/asd_top.sv ***
// clock divider, alignment, filter path and ddr output of the dual receiver
`timescale 1ns/100ps
module asd_top (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_ce,
  input  wire logic                          i_align_in_pos,
  input  wire logic                          i_align_in_neg,
  input  wire asd_pkg::asd_cfg_s             i_cfg,
  input  wire logic signed [asd_pkg::SW-1:0] i_raw [asd_pkg::CH],
  output logic                               o_sub_even_en,
  output logic                               o_sub_odd_en,
  output asd_pkg::asd_ddr_s                  o_ddr [asd_pkg::CH],
  output logic [9:0]                         o_swing_mv
);
  import asd_pkg::*;

  asd_cfg_s            cfg_q;
  asd_phase_e          phase;
  logic                pos_s1;
  logic                pos_s2;
  logic                neg_s1;
  logic                neg_s2;
  logic                diff_q;
  logic                diff_lvl;
  logic                align_rise;
  logic signed [SW-1:0] filt_out [CH];
  logic signed [SW-1:0] byp_q    [CH];
  logic [SW-1:0]       word_q   [CH];
  logic [NS_W-1:0]     ns_err   [CH];

  // saturating left shift for the filter gain
  function automatic logic signed [SW-1:0] gain_shl(input logic signed [SW-1:0] x,
                                                    input logic [GAIN_W-1:0] sh);
    logic signed [SW+2:0] w;
    w = {{3{x[SW-1]}}, x} <<< sh;
    if (w[SW+2:SW-1] == '0 || w[SW+2:SW-1] == '1) return w[SW-1:0];
    return w[SW+2] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
  endfunction : gain_shl

  // add the carried error to a sample, clamping at the top code
  function automatic logic signed [SW-1:0] add_err(input logic signed [SW-1:0] x,
                                                   input logic [NS_W-1:0] e);
    logic signed [SW:0] t;
    t = {x[SW-1], x} + {{(SW+1-NS_W){1'b0}}, e};
    if (t[SW] != t[SW-1]) return {1'b0, {(SW-1){1'b1}}};
    return t[SW-1:0];
  endfunction : add_err

  ////////////////////////////////////////////////////////////////////////////
  // configuration

  // settings held in flops so reset gives defined modes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_q <= CFG_RST;
    end else if (i_ce) begin
      cfg_q <= i_cfg;
    end
  end

  // output swing level to the line drivers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_swing_mv <= SWING_NOM_MV;
    end else if (i_ce) begin
      o_swing_mv <= SWING_MV_TAB[cfg_q.swing];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // align input

  // two-flop synchronisers on both pins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pos_s1 <= 1'b0;
      pos_s2 <= 1'b0;
      neg_s1 <= 1'b1;
      neg_s2 <= 1'b1;
    end else if (i_ce) begin
      pos_s1 <= i_align_in_pos;
      pos_s2 <= pos_s1;
      neg_s1 <= i_align_in_neg;
      neg_s2 <= neg_s1;
    end
  end

  // differential level: positive pin above negative pin
  assign diff_lvl = pos_s2 & ~neg_s2;

  // previous level for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      diff_q <= 1'b0;
    end else if (i_ce) begin
      diff_q <= diff_lvl;
    end
  end

  // any rising edge is taken as alignment unless disabled
  assign align_rise = diff_lvl & ~diff_q & ~cfg_q.align_input_disable;

  ////////////////////////////////////////////////////////////////////////////
  // clock divider

  // divide by two; free phase until an align rise forces even
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase <= PH_RST;
    end else if (i_ce) begin
      if (align_rise) begin
        phase <= PH_ALIGN;
      end else begin
        phase <= (phase == PH_EVEN) ? PH_ODD : PH_EVEN;
      end
    end
  end

  // sub-converter strobes follow the divider
  assign o_sub_even_en = (phase == PH_EVEN);
  assign o_sub_odd_en  = (phase == PH_ODD);

  ////////////////////////////////////////////////////////////////////////////
  // per channel data path

  generate
    for (genvar c = 0; c < CH; c++) begin : g_ch
      logic signed [SW-1:0] src;
      logic signed [SW-1:0] ns_sum;

      asd_dec_filter #(
        .W  (SW),
        .NT (TAPS_HI)
      ) u_filt (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_ce     (i_ce),
        .i_load   (phase == PH_ODD),
        .i_hp     (cfg_q.hp[c]),
        .i_ord20  (cfg_q.ord20[c]),
        .i_sample (i_raw[c]),
        .o_sample (filt_out[c])
      );

      // bypass path keeps the raw sample of each odd phase
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          byp_q[c] <= '0;
        end else if (i_ce && phase == PH_ODD) begin
          byp_q[c] <= i_raw[c];
        end
      end

      // gain only applies to filtered data
      assign src    = cfg_q.bypass ? byp_q[c]
                                   : gain_shl(filt_out[c], cfg_q.gain_sh);
      assign ns_sum = add_err(src, ns_err[c]);

      // resolution select and noise shaping
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          word_q[c] <= '0;
          ns_err[c] <= '0;
        end else if (i_ce && phase == PH_EVEN) begin
          if (cfg_q.res14) begin
            word_q[c] <= src;
            ns_err[c] <= '0;
          end else if (cfg_q.ns_en) begin
            word_q[c] <= {{NS_W{1'b0}}, ns_sum[SW-1:NS_W]};
            ns_err[c] <= ns_sum[NS_W-1:0];
          end else begin
            word_q[c] <= {{NS_W{1'b0}}, src[SW-1:NS_W]};
            ns_err[c] <= '0;
          end
        end
      end

      asd_ddr_ser u_ser (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_phase (phase),
        .i_res14 (cfg_q.res14),
        .i_word  (word_q[c]),
        .o_ddr   (o_ddr[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_two_ce;
    i_ce ##1 i_ce;
  endsequence

  sequence s_pin_rise;
    $rose(diff_lvl) && !cfg_q.align_input_disable && i_ce;
  endsequence

  sequence s_free_run;
    i_ce && !align_rise;
  endsequence

  a_div_toggle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_free_run ##1 i_ce |-> phase != $past(phase))
    else $error("divider did not toggle");

  a_align_force: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    align_rise && i_ce |=> phase == PH_ALIGN)
    else $error("align rise did not force divider");

  a_align_detect: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_pin_rise |-> align_rise)
    else $error("align pin edge missed");

  a_align_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cfg_q.align_input_disable |-> !align_rise)
    else $error("align taken while disabled");

  a_order_reset: assert property (@(posedge i_clk)
    $rose(i_rst_n) |-> cfg_q.ord20 == '0 && cfg_q.bypass == 1'b0)
    else $error("filter order not 12th after reset");

  a_swing_nominal: assert property (@(posedge i_clk)
    $rose(i_rst_n) |-> o_swing_mv == SWING_NOM_MV)
    else $error("swing not nominal after reset");

  a_sub_enables: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_sub_even_en != o_sub_odd_en)
    else $error("sub-converter strobes overlap");

  a_bypass_path: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && phase == PH_EVEN && cfg_q.bypass && cfg_q.res14 |=> word_q[0] == $past(byp_q[0]))
    else $error("bypass word not raw sample");

  a_ns_off_14: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && phase == PH_EVEN && cfg_q.res14 |=> ns_err[0] == '0)
    else $error("noise shaping active in 14-bit mode");

  a_ddr_clock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_free_run ##1 s_two_ce |-> o_ddr[0].out_clock != $past(o_ddr[0].out_clock))
    else $error("output clock did not toggle");

endmodule : asd_top

// *** design/asd_pkg.sv ***
// shared constants and carrier types for the converter back end
package asd_pkg;

  localparam int CH      = 2;   // channels
  localparam int SW      = 14;  // full resolution sample width
  localparam int RES_LO  = 9;   // reduced resolution width
  localparam int PAIRS   = 7;   // ddr pairs per channel
  localparam int NS_W    = SW - RES_LO; // bits dropped in 9-bit mode
  localparam int GAIN_W  = 2;   // filter gain shift field width

  // filter order and tap counts
  localparam int ORD_LO  = 12;
  localparam int ORD_HI  = 20;
  localparam int TAPS_LO = ORD_LO + 1;
  localparam int TAPS_HI = ORD_HI + 1;
  localparam int SH_LO   = 4;   // output scaling, 12th order
  localparam int SH_HI   = 5;   // output scaling, 20th order

  // clock and divider
  localparam int CLK_NS     = 4;  // sample clock period
  localparam int DIV_RATIO  = 2;  // sample clock divide ratio

  // output swing table in millivolts, index 0 is nominal
  localparam logic [2:0] SWING_SEL_RST = 3'h0;
  localparam logic [9:0] SWING_NOM_MV  = 10'h15E;
  localparam logic [9:0] SWING_MV_TAB [8] = '{
    10'h15E, 10'h078, 10'h0C8, 10'h0FA, 10'h12C, 10'h190, 10'h1F4, 10'h258};

  // divider phase
  typedef enum logic {PH_EVEN, PH_ODD} asd_phase_e;
  localparam asd_phase_e PH_RST   = PH_EVEN;
  localparam asd_phase_e PH_ALIGN = PH_EVEN;

  // configuration bits
  typedef struct packed {
    logic [CH-1:0]     hp;        // high-pass per channel
    logic [CH-1:0]     ord20;     // 20th order per channel
    logic              bypass;    // decimation filter bypass
    logic              res14;     // 14-bit output mode
    logic              ns_en;     // noise shaping in 9-bit mode
    logic              align_input_disable;
    logic [GAIN_W-1:0] gain_sh;   // filter gain, left shift
    logic [2:0]        swing;     // output swing select
  } asd_cfg_s;

  localparam asd_cfg_s CFG_RST = '{hp: '0, ord20: '0, bypass: 1'b0, res14: 1'b1,
    ns_en: 1'b0, align_input_disable: 1'b0, gain_sh: '0, swing: SWING_SEL_RST};

  // one channel of ddr output
  typedef struct packed {
    logic [PAIRS-1:0] pair;
    logic             out_clock;
  } asd_ddr_s;

endpackage : asd_pkg

// *** design/asd_dec_filter.sv ***
// decimating low-pass / high-pass filter for one channel
`timescale 1ns/100ps
module asd_dec_filter #(
  parameter int W  = asd_pkg::SW,
  parameter int NT = asd_pkg::TAPS_HI
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_ce,
  input  wire logic                i_load,
  input  wire logic                i_hp,
  input  wire logic                i_ord20,
  input  wire logic signed [W-1:0] i_sample,
  output logic signed [W-1:0]      o_sample
);
  import asd_pkg::*;

  logic signed [W-1:0] tap  [NT];
  logic signed [W+4:0] term [NT];
  logic signed [W+4:0] acc;

  // delay line on interleaved even/odd samples
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < NT; k++) tap[k] <= '0;
    end else if (i_ce) begin
      tap[0] <= i_sample;
      for (int k = 1; k < NT; k++) tap[k] <= tap[k-1];
    end
  end

  // taps: beyond the order are muted, odd taps negated for high-pass
  generate
    for (genvar k = 0; k < NT; k++) begin : g_tap
      logic signed [W+4:0] ext;
      assign ext     = {{5{tap[k][W-1]}}, tap[k]};
      assign term[k] = (!i_ord20 && k >= TAPS_LO) ? '0 :
                       (i_hp && (k % 2 == 1)) ? -ext : ext;
    end
  endgenerate

  // adder tree
  always_comb begin
    acc = '0;
    for (int k = 0; k < NT; k++) acc = acc + term[k];
  end

  // decimated output, one word per two input samples
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sample <= '0;
    end else if (i_ce && i_load) begin
      o_sample <= i_ord20 ? W'(acc >>> SH_HI) : W'(acc >>> SH_LO);
    end
  end

endmodule : asd_dec_filter

// *** design/asd_ddr_ser.sv ***
// two bits per pair per output clock period serializer
`timescale 1ns/100ps
module asd_ddr_ser (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  input  wire asd_pkg::asd_phase_e   i_phase,
  input  wire logic                  i_res14,
  input  wire logic [asd_pkg::SW-1:0] i_word,
  output asd_pkg::asd_ddr_s          o_ddr
);
  import asd_pkg::*;

  logic [SW-1:0] hold;

  // pick one bit of each pair: even bits on rising half, odd on falling
  function automatic logic [PAIRS-1:0] half_bits(input logic [SW-1:0] w,
                                                 input logic odd, input logic res14);
    logic [PAIRS-1:0] r;
    r = '0;
    for (int k = 0; k < PAIRS; k++) begin
      if (res14 || (2*k + int'(odd)) < RES_LO) r[k] = w[2*k + int'(odd)];
    end
    return r;
  endfunction : half_bits

  // word taken at the end of the odd phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hold <= '0;
    end else if (i_ce && i_phase == PH_ODD) begin
      hold <= i_word;
    end
  end

  // registered pins, clock high with even bits
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ddr <= '0;
    end else if (i_ce) begin
      o_ddr.out_clock <= (i_phase == PH_EVEN);
      o_ddr.pair      <= half_bits(hold, i_phase == PH_ODD, i_res14);
    end
  end

endmodule : asd_ddr_ser

// *** dv/asd_ddr_capture.sv ***
// capture receiver model that rebuilds sample words from one ddr channel
`timescale 1ns/100ps
module asd_ddr_capture (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire asd_pkg::asd_ddr_s i_ddr,
  output logic [asd_pkg::SW-1:0] o_word,
  output logic                   o_clk_err
);
  import asd_pkg::*;

  logic [PAIRS-1:0] even_q;
  logic             oclk_q;
  logic             seen_q;

  ////////////////////////////////////////////////////////////////////////////
  // high half of the output clock holds even bits, low half odd bits
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      even_q <= '0;
      o_word <= '0;
    end else if (i_ddr.out_clock) begin
      even_q <= i_ddr.pair;
    end else begin
      for (int k = 0; k < PAIRS; k++) begin
        o_word[2*k]   <= even_q[k];
        o_word[2*k+1] <= i_ddr.pair[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flag when the output clock fails to alternate once running
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      oclk_q    <= 1'b0;
      seen_q    <= 1'b0;
      o_clk_err <= 1'b0;
    end else begin
      oclk_q <= i_ddr.out_clock;
      seen_q <= seen_q | i_ddr.out_clock;
      if (seen_q && i_ddr.out_clock == oclk_q) begin
        o_clk_err <= 1'b1;
      end
    end
  end
endmodule : asd_ddr_capture

// *** dv/asd_top_bench.sv ***
// self-checking bench for swing, data path, divider and alignment
`timescale 1ns/100ps
module asd_top_bench;
  import asd_pkg::*;

  logic                 clk;
  logic                 rst_n;
  logic                 ce;
  logic                 pos;
  logic                 neg;
  logic                 even_en;
  logic                 odd_en;
  asd_cfg_s             cfg;
  logic signed [SW-1:0] raw [CH];
  asd_ddr_s             ddr [CH];
  logic [9:0]           swing_mv;
  logic [SW-1:0]        word [CH];
  logic [CH-1:0]        clk_err;
  logic [SW-1:0]        w0;
  logic                 p;
  int                   fail_count;
  int                   checks;
  logic [9:0]           swing_exp [8] = '{10'h15E, 10'h078, 10'h0C8, 10'h0FA,
                                          10'h12C, 10'h190, 10'h1F4, 10'h258};

  ////////////////////////////////////////////////////////////////////////////
  // design and one capture model per channel
  asd_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_align_in_pos(pos),
    .i_align_in_neg(neg), .i_cfg(cfg), .i_raw(raw), .o_sub_even_en(even_en),
    .o_sub_odd_en(odd_en), .o_ddr(ddr), .o_swing_mv(swing_mv));

  for (genvar c = 0; c < CH; c++) begin : g_cap
    asd_ddr_capture u_cap (.i_clk(clk), .i_rst_n(rst_n), .i_ddr(ddr[c]),
      .o_word(word[c]), .o_clk_err(clk_err[c]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #20000;
    fail_count++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict and align pulse helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // three edges after the pins change the divider is forced even or has run on
  task automatic align_try(input logic up, input logic forced);
    logic p0;
    @(negedge clk);
    p0 = even_en;
    pos = up;
    neg = !up;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("sub_even_en", 16'(even_en), 16'(forced | !p0));
    repeat (3) @(negedge clk);
  endtask : align_try

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    pos = 1'b0;
    neg = 1'b1;
    cfg = CFG_RST;
    raw[0] = '0;
    raw[1] = '0;
    fail_count = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("swing_mv_rst", 16'(swing_mv), 16'h015E);
    check("sub_even_rst", 16'(even_en), 16'h0001);
    check("ddr_rst", 16'(ddr[0]), 16'h0000);
    rst_n = 1'b1;
    // divider toggles every edge and the two enables stay opposite
    for (int i = 0; i < 4; i++) begin
      p = even_en;
      check("sub_odd_en", 16'(odd_en), 16'(!p));
      @(negedge clk);
      check("sub_even_toggle", 16'(even_en), 16'(!p));
    end
    // whole swing table
    for (int i = 0; i < 8; i++) begin
      cfg.swing = 3'(i);
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("swing_mv", 16'(swing_mv), 16'(swing_exp[i]));
    end
    // bypass passes samples without gain, shaping ignored in 14-bit mode
    cfg.bypass = 1'b1;
    cfg.gain_sh = 2'h3;
    cfg.ns_en = 1'b1;
    raw[0] = 14'h2A5C;
    raw[1] = 14'h1B3D;
    repeat (40) @(negedge clk);
    check("word0_bypass", 16'(word[0]), 16'h2A5C);
    check("word1_bypass", 16'(word[1]), 16'h1B3D);
    cfg.res14 = 1'b0;
    repeat (40) @(negedge clk);
    check("word0_hi9", 16'(word[0][13:9]), 16'h0000);
    check("word1_hi9", 16'(word[1][13:9]), 16'h0000);
    check("out_clock_err", 16'(clk_err), 16'h0000);
    // per channel filter settings leave the other channel untouched
    cfg = CFG_RST;
    raw[0] = 14'h0400;
    raw[1] = 14'h0400;
    for (int j = 0; j < 2; j++) begin
      cfg.hp = '0;
      cfg.ord20 = '0;
      repeat (60) @(negedge clk);
      w0 = word[0];
      check("word0_lp12", 16'(w0), 16'h0340);
      check("word1_same", 16'(word[1]), 16'(w0));
      if (j == 0) begin
        cfg.hp[1] = 1'b1;
      end else begin
        cfg.ord20[1] = 1'b1;
      end
      repeat (60) @(negedge clk);
      check("word0_kept", 16'(word[0]), 16'(w0));
      check("word1_mode", 16'(word[1]), (j == 0) ? 16'h0040 : 16'h02A0);
    end
    // rising align forces even phase, falling is ignored, two phase offsets
    for (int k = 0; k < 2; k++) begin
      repeat (k) @(negedge clk);
      align_try(1'b1, 1'b1);
      align_try(1'b0, 1'b0);
    end
    // disabled align input is ignored completely
    cfg.align_input_disable = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      repeat (k) @(negedge clk);
      align_try(1'b1, 1'b0);
      align_try(1'b0, 1'b0);
    end
    // clock enable low freezes the divider
    p = even_en;
    ce = 1'b0;
    repeat (3) @(negedge clk);
    check("sub_even_frozen", 16'(even_en), 16'(p));
    ce = 1'b1;
    summarize();
  end
endmodule : asd_top_bench
